//--- hdl/rxddr_lanes.sv
// Purpose: receive DDR lane formatter for pairs C/D, E/F and A/B bit 9
// Assumes: reference_clock runs free; mode pins are quasi-static
// Notes: words cross from mclk to the link clock through a gray FIFO
//
// Operation
// RL1 - Lanes change on both byte clock edges
// RL2 - Multiplexed: D on rising, C on falling
// RL3 - Multiplexed: F on rising, E on falling
// RL4 - Multiplexed raw: bit 8 is ninth bit
// RL5 - Multiplexed raw: bit 9 is tenth bit
// RL6 - Multiplexed decoded: bit 8 is K flag
// RL7 - Nibble: low nibble falling, high nibble rising
// RL8 - Nibble: C on [4:0], D on [9:5]
// RL9 - Nibble: E on [4:0], F on [9:5]
// RL10 - Nibble decoded: bit 3 lower K rising
// RL11 - Nibble raw: bit 8 is bits 4/9
// RL12 - Nibble raw: bit 9 is bits 5/10
// RL13 - Nibble decoded: bit 8 data, then K
// RL14 - Nibble K flag marks upper byte control
// RL15 - Byte clock is buffered reference clock
// RL16 - Meaningless lane bits drive low
// RL17 - Receiver captures both edges, demultiplexes by mode
`include "rxddr_params.svh"

module rxddr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `RXDDR_FIFO_DEPTH
) (
  // Write side
  input wire logic wclk,
  input wire logic wrst_n,
  input wire logic w_valid,
  input wire logic [WIDTH-1:0] w_data,
  output logic w_ready,
  // Read side
  input wire logic rclk,
  input wire logic rrst_n,
  input wire logic r_ready,
  output logic r_valid,
  output logic [WIDTH-1:0] r_data
);
  localparam int AW = `RXDDR_PTR_W - 1;

  logic [WIDTH-1:0] mem [DEPTH];
  rxddr_pkg::rxddr_fw_t wq;
  rxddr_pkg::rxddr_fw_t next_wq;
  rxddr_pkg::rxddr_fr_t rq;
  rxddr_pkg::rxddr_fr_t next_rq;
  logic push;
  logic pop;

  // Full when the write pointer is one lap ahead of the read pointer
  assign w_ready = wq.gray != {~wq.rg_s2[AW:AW-1], wq.rg_s2[AW-2:0]};
  assign push = w_valid && w_ready;
  assign r_valid = rq.gray != rq.wg_s2;
  assign pop = r_valid && r_ready;
  assign r_data = mem[rq.bin[AW-1:0]];

  always_comb begin
    next_wq = wq;
    next_wq.rg_s1 = rq.gray;
    next_wq.rg_s2 = wq.rg_s1;
    if (push) begin
      next_wq.bin = wq.bin + 1'b1;
      next_wq.gray = rxddr_pkg::to_gray(next_wq.bin);
    end
  end

  always_ff @(posedge wclk or negedge wrst_n) begin
    if (!wrst_n) begin
      wq <= '0;
    end else begin
      wq <= next_wq;
    end
  end

  always_ff @(posedge wclk) begin
    if (push) begin
      mem[wq.bin[AW-1:0]] <= w_data;
    end
  end

  always_comb begin
    next_rq = rq;
    next_rq.wg_s1 = wq.gray;
    next_rq.wg_s2 = rq.wg_s1;
    if (pop) begin
      next_rq.bin = rq.bin + 1'b1;
      next_rq.gray = rxddr_pkg::to_gray(next_rq.bin);
    end
  end

  always_ff @(posedge rclk or negedge rrst_n) begin
    if (!rrst_n) begin
      rq <= '0;
    end else begin
      rq <= next_rq;
    end
  end

endmodule

module rxddr_lanes (
  // System clock domain
  input wire logic mclk,
  input wire logic rst_n,
  // Received words from the decoder side
  input wire logic in_valid,
  input wire rxddr_pkg::rxddr_set_t in_set,
  output logic in_ready,
  // Interface mode pins
  input wire logic nibble_mode,
  input wire logic decoder_select,
  // Link clock
  input wire logic reference_clock,
  output logic rx_byte_clock,
  // Lane outputs
  output logic rx_lane_ab_bit9,
  output logic [7:0] rx_lane_cd_low_bits,
  output logic rx_lane_cd_bit8,
  output logic rx_lane_cd_bit9,
  output logic [7:0] rx_lane_ef_low_bits,
  output logic rx_lane_ef_bit8,
  output logic rx_lane_ef_bit9
);
  localparam int SET_W = $bits(rxddr_pkg::rxddr_set_t);

  rxddr_pkg::rxddr_link_t q;
  rxddr_pkg::rxddr_link_t next_q;
  rxddr_pkg::rxddr_set_t rd;
  rxddr_pkg::rxddr_half_t h_cd;
  rxddr_pkg::rxddr_half_t h_ef;
  rxddr_pkg::rxddr_half_t h_ab;
  logic [SET_W-1:0] rd_bits;
  logic rd_valid;
  logic pop;
  logic lrst_meta;
  logic lrst_n;
  logic [`RXDDR_WORD_W-1:0] lane_cd;
  logic [`RXDDR_WORD_W-1:0] lane_ef;

  // Lane halves for one pair; l is the lower channel, u the upper
  function automatic rxddr_pkg::rxddr_half_t pair_lanes(
    input rxddr_pkg::rxddr_chan_t l,
    input rxddr_pkg::rxddr_chan_t u,
    input logic [1:0] mode
  );
    rxddr_pkg::rxddr_half_t h;
    h = '0;
    case (mode)
      `RXDDR_MODE_MUX_RAW: begin
        h.rise = u.w; // RL4 RL5
        h.fall = l.w;
      end
      `RXDDR_MODE_MUX_DEC: begin
        h.rise = {1'b0, u.k, u.w[7:0]}; // RL6 RL16
        h.fall = {1'b0, l.k, l.w[7:0]};
      end
      `RXDDR_MODE_NIB_RAW: begin
        h.fall = {u.w[4:0], l.w[4:0]}; // RL7 RL11 RL12
        h.rise = {u.w[9:5], l.w[9:5]};
      end
      default: begin
        // Flags take bits 8 and 3 on the rising half
        h.fall = {1'b0, u.w[3:0], 1'b0, l.w[3:0]}; // RL13 RL16
        h.rise = {u.w[7], u.k, u.w[6:4], l.w[7], l.k, l.w[6:4]}; // RL10 RL14
      end
    endcase
    return h;
  endfunction

  // Words cross into the link domain; a stall reaches in_ready
  rxddr_fifo #(
    .WIDTH(SET_W),
    .DEPTH(`RXDDR_FIFO_DEPTH)
  ) u_fifo (
    .wclk(mclk),
    .wrst_n(rst_n),
    .w_valid(in_valid),
    .w_data(in_set),
    .w_ready(in_ready),
    .rclk(reference_clock),
    .rrst_n(lrst_n),
    .r_ready(lrst_n),
    .r_valid(rd_valid),
    .r_data(rd_bits)
  );

  // Reset asserts at once but releases on the link clock
  always_ff @(posedge reference_clock or negedge rst_n) begin
    if (!rst_n) begin
      lrst_meta <= 1'b0;
      lrst_n <= 1'b0;
    end else begin
      lrst_meta <= 1'b1;
      lrst_n <= lrst_meta;
    end
  end

  assign rd = rd_bits;
  assign pop = rd_valid && lrst_n;
  assign h_cd = pair_lanes(rd.c, rd.d, q.mode_s2); // RL8
  assign h_ef = pair_lanes(rd.e, rd.f, q.mode_s2); // RL9
  assign h_ab = pair_lanes('0, rd.b, q.mode_s2);

  // Each set shows its falling half first, then its rising half
  always_comb begin
    next_q = q;
    next_q.mode_s1 = {nibble_mode, decoder_select};
    next_q.mode_s2 = q.mode_s1;
    next_q.rise_cd = q.pend_cd;
    next_q.rise_ef = q.pend_ef;
    next_q.rise_ab9 = q.pend_ab9;
    next_q.fall_cd = `RXDDR_LANE_RST;
    next_q.pend_cd = `RXDDR_LANE_RST;
    next_q.fall_ef = `RXDDR_LANE_RST;
    next_q.pend_ef = `RXDDR_LANE_RST;
    next_q.fall_ab9 = 1'b0;
    next_q.pend_ab9 = 1'b0;
    if (pop) begin
      next_q.fall_cd = h_cd.fall; // RL2
      next_q.pend_cd = h_cd.rise;
      next_q.fall_ef = h_ef.fall; // RL3
      next_q.pend_ef = h_ef.rise;
      next_q.fall_ab9 = h_ab.fall[9]; // RL5
      next_q.pend_ab9 = h_ab.rise[9];
    end
  end

  always_ff @(posedge reference_clock or negedge lrst_n) begin
    if (!lrst_n) begin
      q.mode_s1 <= `RXDDR_MODE_RST;
      q.mode_s2 <= `RXDDR_MODE_RST;
      q.fall_cd <= `RXDDR_LANE_RST;
      q.pend_cd <= `RXDDR_LANE_RST;
      q.rise_cd <= `RXDDR_LANE_RST;
      q.fall_ef <= `RXDDR_LANE_RST;
      q.pend_ef <= `RXDDR_LANE_RST;
      q.rise_ef <= `RXDDR_LANE_RST;
      q.fall_ab9 <= 1'b0;
      q.pend_ab9 <= 1'b0;
      q.rise_ab9 <= 1'b0;
    end else begin
      q <= next_q;
    end
  end

  // Clock-steered select keeps both halves in flops; the output
  // pads must keep this mux glitch-free across the edge
  assign rx_byte_clock = reference_clock; // RL15
  assign lane_cd = reference_clock ? q.rise_cd : q.fall_cd; // RL1
  assign lane_ef = reference_clock ? q.rise_ef : q.fall_ef; // RL1
  assign rx_lane_ab_bit9 = reference_clock ? q.rise_ab9 : q.fall_ab9;
  assign rx_lane_cd_low_bits = lane_cd[7:0];
  assign rx_lane_cd_bit8 = lane_cd[8];
  assign rx_lane_cd_bit9 = lane_cd[9];
  assign rx_lane_ef_low_bits = lane_ef[7:0];
  assign rx_lane_ef_bit8 = lane_ef[8];
  assign rx_lane_ef_bit9 = lane_ef[9];

  a_ddr_rise_follow: assert property ( // RL1
    @(posedge reference_clock) disable iff (!lrst_n)
    pop |=> ##1 (q.rise_cd == $past(h_cd.rise, 2))
      && (q.rise_ef == $past(h_ef.rise, 2)))
    else $error("rising half not taken one cycle after falling");

  a_mux_cd_order: assert property ( // RL2
    @(posedge reference_clock) disable iff (!lrst_n)
    (pop && q.mode_s2 == `RXDDR_MODE_MUX_RAW)
    |=> (q.fall_cd == $past(rd.c.w))
    ##1 (q.rise_cd == $past(rd.d.w, 2)))
    else $error("C/D word order wrong in multiplexed mode");

  a_mux_ef_order: assert property ( // RL3
    @(posedge reference_clock) disable iff (!lrst_n)
    (pop && q.mode_s2 == `RXDDR_MODE_MUX_RAW)
    |=> (q.fall_ef == $past(rd.e.w))
    ##1 (q.rise_ef == $past(rd.f.w, 2)))
    else $error("E/F word order wrong in multiplexed mode");

  a_mux_bit_eight: assert property ( // RL4
    @(posedge reference_clock) disable iff (!lrst_n)
    (pop && q.mode_s2 == `RXDDR_MODE_MUX_RAW)
    |=> q.fall_ef[8] == $past(rd.e.w[8]))
    else $error("bit 8 not ninth word bit");

  a_mux_bit_nine: assert property ( // RL5
    @(posedge reference_clock) disable iff (!lrst_n)
    (pop && q.mode_s2 == `RXDDR_MODE_MUX_RAW)
    |=> ##1 q.rise_ab9 == $past(rd.b.w[9], 2))
    else $error("A/B bit 9 not tenth word bit");

  a_mux_k_flag: assert property ( // RL6
    @(posedge reference_clock) disable iff (!lrst_n)
    (pop && q.mode_s2 == `RXDDR_MODE_MUX_DEC)
    |=> (q.fall_cd[8] == $past(rd.c.k)) && !q.fall_cd[9])
    else $error("K flag or low bit 9 wrong in decoded mode");

  a_nib_order: assert property ( // RL7
    @(posedge reference_clock) disable iff (!lrst_n)
    (pop && q.mode_s2 == `RXDDR_MODE_NIB_RAW)
    |=> (q.fall_cd[4:0] == $past(rd.c.w[4:0]))
    ##1 (q.rise_cd[4:0] == $past(rd.c.w[9:5], 2)))
    else $error("nibble order wrong on C");

  a_nib_upper: assert property ( // RL9
    @(posedge reference_clock) disable iff (!lrst_n)
    (pop && q.mode_s2 == `RXDDR_MODE_NIB_RAW)
    |=> q.fall_ef[9:5] == $past(rd.f.w[4:0]))
    else $error("channel F not on upper lane bits");

  a_nib_raw_top: assert property ( // RL11
    @(posedge reference_clock) disable iff (!lrst_n)
    (pop && q.mode_s2 == `RXDDR_MODE_NIB_RAW)
    |=> ##1 q.rise_cd[9:8] == $past(rd.d.w[9:8], 2))
    else $error("bits 9 and 10 of D missing on rising half");

  a_nib_k_flags: assert property ( // RL13
    @(posedge reference_clock) disable iff (!lrst_n)
    (pop && q.mode_s2 == `RXDDR_MODE_NIB_DEC)
    |=> (q.fall_cd[8] == $past(rd.d.w[3]))
    ##1 (q.rise_cd[8] == $past(rd.d.k, 2))
      && (q.rise_cd[3] == $past(rd.c.k, 2)))
    else $error("nibble K flags misplaced");

  a_mux_dec_upper: assert property ( // RL6
    @(posedge reference_clock) disable iff (!lrst_n)
    (pop && q.mode_s2 == `RXDDR_MODE_MUX_DEC)
    |=> ##1 ((q.rise_ef[8] == $past(rd.f.k, 2)) && !q.rise_ef[9]))
    else $error("upper K flag or bit 9 wrong in decoded mode");

  a_nib_cd_upper: assert property ( // RL8
    @(posedge reference_clock) disable iff (!lrst_n)
    (pop && q.mode_s2 == `RXDDR_MODE_NIB_RAW)
    |=> q.fall_cd[9:5] == $past(rd.d.w[4:0]))
    else $error("channel D not on upper lane bits");

  a_nib_lower_k: assert property ( // RL10
    @(posedge reference_clock) disable iff (!lrst_n)
    (pop && q.mode_s2 == `RXDDR_MODE_NIB_DEC)
    |=> ##1 q.rise_ef[3] == $past(rd.e.k, 2))
    else $error("lower K flag not on bit 3 of rising half");

  a_nib_raw_nine: assert property ( // RL12
    @(posedge reference_clock) disable iff (!lrst_n)
    (pop && q.mode_s2 == `RXDDR_MODE_NIB_RAW)
    |=> (q.fall_ef[9] == $past(rd.f.w[4]))
    ##1 (q.rise_ef[9] == $past(rd.f.w[9], 2)))
    else $error("bit 9 not fifth and tenth bits of F");

  a_nib_dec_low: assert property ( // RL16
    @(posedge reference_clock) disable iff (!lrst_n)
    (pop && q.mode_s2 == `RXDDR_MODE_NIB_DEC)
    |=> !q.fall_cd[9] && !q.fall_cd[4] && !q.fall_ef[9] && !q.fall_ef[4])
    else $error("unused falling lane bits not low");

endmodule

//--- pkg/rxddr_params.svh
// Purpose: constants for the receive DDR lane formatter
// Assumes: included by the package and by the design file
// Notes: reset values and mode codes for the lane logic
`ifndef RXDDR_PARAMS_SVH
`define RXDDR_PARAMS_SVH

`define RXDDR_WORD_W 10
`define RXDDR_FIFO_DEPTH 16
`define RXDDR_PTR_W 5
`define RXDDR_LANE_RST 10'h000
`define RXDDR_MODE_RST 2'h0
`define RXDDR_MODE_MUX_RAW 2'h0
`define RXDDR_MODE_MUX_DEC 2'h1
`define RXDDR_MODE_NIB_RAW 2'h2
`define RXDDR_MODE_NIB_DEC 2'h3

`endif

//--- pkg/rxddr_pkg.sv
// Purpose: types for the receive DDR lane formatter
// Assumes: rxddr_params.svh holds the widths
// Notes: one channel is a 10-bit word plus a control-character flag
`include "rxddr_params.svh"

package rxddr_pkg;

  // Raw mode uses w[9:0]; decoded mode uses w[7:0] and k
  typedef struct packed {
    logic k;
    logic [`RXDDR_WORD_W-1:0] w;
  } rxddr_chan_t;

  // One word for each channel that feeds these lanes
  typedef struct packed {
    rxddr_chan_t b;
    rxddr_chan_t c;
    rxddr_chan_t d;
    rxddr_chan_t e;
    rxddr_chan_t f;
  } rxddr_set_t;

  typedef struct packed {
    logic [`RXDDR_WORD_W-1:0] rise;
    logic [`RXDDR_WORD_W-1:0] fall;
  } rxddr_half_t;

  // FIFO write side state
  typedef struct packed {
    logic [`RXDDR_PTR_W-1:0] bin;
    logic [`RXDDR_PTR_W-1:0] gray;
    logic [`RXDDR_PTR_W-1:0] rg_s1;
    logic [`RXDDR_PTR_W-1:0] rg_s2;
  } rxddr_fw_t;

  // FIFO read side state
  typedef struct packed {
    logic [`RXDDR_PTR_W-1:0] bin;
    logic [`RXDDR_PTR_W-1:0] gray;
    logic [`RXDDR_PTR_W-1:0] wg_s1;
    logic [`RXDDR_PTR_W-1:0] wg_s2;
  } rxddr_fr_t;

  // Link side state: lane halves and the mode synchroniser
  typedef struct packed {
    logic [1:0] mode_s1;
    logic [1:0] mode_s2;
    logic [`RXDDR_WORD_W-1:0] fall_cd;
    logic [`RXDDR_WORD_W-1:0] pend_cd;
    logic [`RXDDR_WORD_W-1:0] rise_cd;
    logic [`RXDDR_WORD_W-1:0] fall_ef;
    logic [`RXDDR_WORD_W-1:0] pend_ef;
    logic [`RXDDR_WORD_W-1:0] rise_ef;
    logic fall_ab9;
    logic pend_ab9;
    logic rise_ab9;
  } rxddr_link_t;

  function automatic logic [`RXDDR_PTR_W-1:0] to_gray(
    input logic [`RXDDR_PTR_W-1:0] b
  );
    return b ^ (b >> 1);
  endfunction

endpackage

//--- bench/rxddr_proto_model.sv
// Purpose: protocol device model latching the receive DDR lanes
// Assumes: byte clock phases last 62.5 ns
// Notes: one capture is a falling half followed by a rising half
module rxddr_proto_model (
  // Byte clock
  input wire logic rx_byte_clock,
  // Lanes
  input wire logic rx_lane_ab_bit9,
  input wire logic [7:0] rx_lane_cd_low_bits,
  input wire logic rx_lane_cd_bit8,
  input wire logic rx_lane_cd_bit9,
  input wire logic [7:0] rx_lane_ef_low_bits,
  input wire logic rx_lane_ef_bit8,
  input wire logic rx_lane_ef_bit9,
  // Captured set
  output logic [41:0] cap,
  output logic cap_tgl
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] cd_f;
  logic [9:0] ef_f;
  logic ab_f;
  initial begin
    cap = 42'h0;
    cap_tgl = 1'b0;
    // Start on a rising edge so each capture pairs a falling half with the next rising half
    @(posedge rx_byte_clock);
    forever begin
      // Mid-phase sampling stays clear of the clock-selected output mux
      @(negedge rx_byte_clock);
      #31;
      cd_f = {rx_lane_cd_bit9, rx_lane_cd_bit8, rx_lane_cd_low_bits};
      ef_f = {rx_lane_ef_bit9, rx_lane_ef_bit8, rx_lane_ef_low_bits};
      ab_f = rx_lane_ab_bit9;
      @(posedge rx_byte_clock);
      #31;
      cap = {rx_lane_cd_bit9, rx_lane_cd_bit8, rx_lane_cd_low_bits, cd_f,
        rx_lane_ef_bit9, rx_lane_ef_bit8, rx_lane_ef_low_bits, ef_f,
        rx_lane_ab_bit9, ab_f};
      cap_tgl = ~cap_tgl;
    end
  end
endmodule

//--- bench/rxddr_lanes_tb_top.sv
// Purpose: self-checking bench for the receive DDR lane formatter
// Assumes: link clock 125 ns, mclk 4 ns
// Notes: channel C bit 0 is forced high so every set shows on the lanes
`include "rxddr_params.svh"
module rxddr_lanes_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst_n, in_valid, in_ready, nibble_mode, decoder_select;
  logic reference_clock, rx_byte_clock, rx_lane_ab_bit9;
  logic [7:0] rx_lane_cd_low_bits, rx_lane_ef_low_bits;
  logic rx_lane_cd_bit8, rx_lane_cd_bit9, rx_lane_ef_bit8, rx_lane_ef_bit9;
  rxddr_pkg::rxddr_set_t in_set;
  logic [41:0] cap;
  logic cap_tgl, saw_full;
  logic [1:0] mode;
  logic [41:0] exp_q[$];
  int n_mismatch, checked;

  rxddr_lanes uut (.mclk(mclk), .rst_n(rst_n), .in_valid(in_valid),
    .in_set(in_set), .in_ready(in_ready), .nibble_mode(nibble_mode),
    .decoder_select(decoder_select), .reference_clock(reference_clock),
    .rx_byte_clock(rx_byte_clock), .rx_lane_ab_bit9(rx_lane_ab_bit9),
    .rx_lane_cd_low_bits(rx_lane_cd_low_bits),
    .rx_lane_cd_bit8(rx_lane_cd_bit8), .rx_lane_cd_bit9(rx_lane_cd_bit9),
    .rx_lane_ef_low_bits(rx_lane_ef_low_bits),
    .rx_lane_ef_bit8(rx_lane_ef_bit8), .rx_lane_ef_bit9(rx_lane_ef_bit9));

  rxddr_proto_model far (.rx_byte_clock(rx_byte_clock),
    .rx_lane_ab_bit9(rx_lane_ab_bit9),
    .rx_lane_cd_low_bits(rx_lane_cd_low_bits),
    .rx_lane_cd_bit8(rx_lane_cd_bit8), .rx_lane_cd_bit9(rx_lane_cd_bit9),
    .rx_lane_ef_low_bits(rx_lane_ef_low_bits),
    .rx_lane_ef_bit8(rx_lane_ef_bit8), .rx_lane_ef_bit9(rx_lane_ef_bit9),
    .cap(cap), .cap_tgl(cap_tgl));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    reference_clock = 1'b0;
    #17;
    forever #62.5 reference_clock = ~reference_clock;
  end

  task automatic check_set(input logic [41:0] e, input logic [41:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR lanes expected %h seen %h", e, g);
    end
  endtask
  task automatic check_bit(input string what, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %b seen %b", what, e, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Returns the rising half above the falling half
  function automatic logic [19:0] fmt(input rxddr_pkg::rxddr_chan_t l,
    input rxddr_pkg::rxddr_chan_t u, input logic [1:0] m);
    case (m)
      `RXDDR_MODE_MUX_RAW: return {u.w, l.w};
      `RXDDR_MODE_MUX_DEC: return {1'b0, u.k, u.w[7:0],
        1'b0, l.k, l.w[7:0]};
      `RXDDR_MODE_NIB_RAW: return {u.w[9:5], l.w[9:5],
        u.w[4:0], l.w[4:0]};
      default: return {u.w[7], u.k, u.w[6:4], l.w[7], l.k, l.w[6:4],
        1'b0, u.w[3:0], 1'b0, l.w[3:0]};
    endcase
  endfunction

  // Empty link cycles show zeros and are skipped
  always @(cap_tgl) begin
    if (cap[31:22] !== 10'h000) begin
      if (exp_q.size() == 0) check_set(42'h0, cap);
      else check_set(exp_q.pop_front(), cap);
      check_bit("byte clock", reference_clock, rx_byte_clock);
    end
  end

  // Entered just after an mclk edge; holds the offer until taken
  task automatic push_set;
    rxddr_pkg::rxddr_set_t s;
    logic [63:0] r;
    logic [19:0] ab;
    logic rdy;
    int n;
    r = {$urandom, $urandom};
    s = r[54:0];
    s.c.w[0] = 1'b1;
    ab = fmt('0, s.b, mode);
    in_valid = 1'b1;
    in_set = s;
    n = 0;
    do begin
      #2 rdy = in_ready;
      if (!rdy) saw_full = 1'b1;
      @(posedge mclk);
      #1 n++;
    end while (!rdy && n < 2000);
    if (!rdy) begin
      n_mismatch++;
      tally_and_finish;
    end
    exp_q.push_back({fmt(s.c, s.d, mode), fmt(s.e, s.f, mode),
      ab[19], ab[9]});
  endtask

  initial begin
    int n;
    rst_n = 1'b0;
    in_valid = 1'b0;
    in_set = '0;
    nibble_mode = 1'b0;
    decoder_select = 1'b0;
    mode = 2'h0;
    saw_full = 1'b0;
    n_mismatch = 0;
    checked = 0;
    void'($urandom(24554));
    repeat (2) @(posedge reference_clock);
    @(posedge mclk);
    #1 rst_n = 1'b1;
    for (int m = 0; m < 4; m++) begin
      mode = m[1:0];
      nibble_mode = mode[1];
      decoder_select = mode[0];
      // Mode pins cross two link flops before use
      repeat (4) @(posedge reference_clock);
      @(posedge mclk);
      #1 saw_full = 1'b0;
      repeat (20) push_set;
      in_valid = 1'b0;
      check_bit("fifo full", 1'b1, saw_full);
      for (n = 0; n < 3000 && exp_q.size() > 0; n++) @(posedge mclk);
      if (exp_q.size() > 0) begin
        n_mismatch++;
        tally_and_finish;
      end
      repeat (2) @(posedge reference_clock);
      // Realign to mclk so the next mode change lands like all stimulus
      @(posedge mclk);
      #1 check_bit("ready after drain", 1'b1, in_ready);
    end
    tally_and_finish;
  end
endmodule
